// ### design/gain_ctrl_channel_enable_regs.sv
// gain control and channel enable register group
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`include "gain_ctrl_defs.svh"
module gain_ctrl_channel_enable_regs
  import gain_ctrl_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  // channel sources and device state
  input wire logic [7:0] pdm_source_i,
  input wire logic [7:0] ch_gain_ctrl_en_i,
  input wire logic device_sleep_i,
  // serial output slot
  input wire logic [2:0] slot_index_i,
  input wire logic slot_active_i,
  input wire logic slot_bit_i,
  output logic sdout_o,
  output logic sdout_oe_o,
  // gain control settings
  output logic gain_scheme_o,
  output logic [6:0] enhancer_trigger_threshold_o,
  output logic [6:0] enhancer_gain_ceiling_o,
  output logic [6:0] gain_ctrl_target_level_o,
  output logic [6:0] gain_ctrl_gain_ceiling_o,
  output logic gain_code_reserved_o,
  output logic [7:0] ch_enhancer_on_o,
  output logic [7:0] ch_agc_on_o,
  // channel power
  output logic [7:0] ch_powered_o,
  output logic [2:0] device_mode_o
);
  bank_state_type state;
  bank_state_type next_state;
  logic [7:0] read_value;
  logic [7:0] gated_en;
  logic slot_enabled;

  gain_ctrl_if cfg ();

  gain_level_decoder u_level (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .lv(cfg.level)
  );

  channel_power_ctrl #(
    .CHANNELS(CHANNELS)
  ) u_power (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pw(cfg.power)
  );

  // stored fields feed helpers unchanged, so readback is exact
  assign cfg.thresh_code = state.range_cfg[`LEVEL_MSB:`LEVEL_LSB];
  assign cfg.enh_ceil_code = state.range_cfg[`CEIL_MSB:`CEIL_LSB];
  assign cfg.target_code = state.gain_cfg[`LEVEL_MSB:`LEVEL_LSB];
  assign cfg.agc_ceil_code = state.gain_cfg[`CEIL_MSB:`CEIL_LSB];
  assign cfg.in_en = state.in_en;
  assign cfg.pdm_source = pdm_source_i;
  assign cfg.power_up = state.power_configuration[`POWER_UP_BIT];
  assign cfg.sleep = device_sleep_i;

  // gain control only on powered channels that ask for it
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_gate
      assign gated_en[g] = ch_gain_ctrl_en_i[g] && cfg.powered[g];
    end
  endgenerate

  // slot 0 carries channel 1, held in bit 7
  assign slot_enabled = state.out_en[3'h7 - slot_index_i];

  always_comb begin
    read_value = 8'h00;
    case (reg_addr_i)
      `ADDR_DSP_CONFIG: begin
        read_value = state.dsp_config;
      end
      `ADDR_RANGE_CFG: begin
        read_value = state.range_cfg;
      end
      `ADDR_GAIN_CFG: begin
        read_value = state.gain_cfg;
      end
      `ADDR_IN_EN: begin
        read_value = state.in_en;
      end
      `ADDR_OUT_EN: begin
        read_value = state.out_en;
      end
      `ADDR_POWER_CONFIGURATION: begin
        read_value = state.power_configuration;
      end
      `ADDR_CH_STATUS: begin
        read_value = cfg.powered;
      end
      `ADDR_MODE_STATUS: begin
        read_value = {cfg.mode, 5'h00};
      end
      default: begin
        read_value = 8'h00;
      end
    endcase
  end

  always_comb begin
    next_state = state;
    // read data stands for one cycle only
    next_state.rdata = reg_read_i ? read_value : 8'h00;
    if (reg_write_i) begin
      case (reg_addr_i)
        `ADDR_DSP_CONFIG: begin
          next_state.dsp_config = reg_wdata_i;
        end
        `ADDR_RANGE_CFG: begin
          // reserved codes are kept as written
          next_state.range_cfg = reg_wdata_i;
        end
        `ADDR_GAIN_CFG: begin
          next_state.gain_cfg = reg_wdata_i;
        end
        `ADDR_IN_EN: begin
          next_state.in_en = reg_wdata_i;
        end
        `ADDR_OUT_EN: begin
          next_state.out_en = reg_wdata_i;
        end
        `ADDR_POWER_CONFIGURATION: begin
          next_state.power_configuration = reg_wdata_i;
        end
        default: begin
          next_state.rdata = next_state.rdata;
        end
      endcase
    end
    // registered so the pin never glitches mid-slot
    next_state.sdout_oe = slot_active_i && slot_enabled;
    next_state.sdout = slot_active_i && slot_enabled && slot_bit_i;
    if (state.dsp_config[`SCHEME_SEL_BIT]) begin
      next_state.enh_on = 8'h00;
      next_state.agc_on = gated_en;
    end else begin
      next_state.enh_on = gated_en;
      next_state.agc_on = 8'h00;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= '{
        dsp_config: `RST_DSP_CONFIG,
        range_cfg: `RST_RANGE_CFG,
        gain_cfg: `RST_GAIN_CFG,
        in_en: `RST_IN_EN,
        out_en: `RST_OUT_EN,
        power_configuration: `RST_POWER_CONFIGURATION,
        rdata: 8'h00,
        sdout: 1'b0,
        sdout_oe: 1'b0,
        enh_on: 8'h00,
        agc_on: 8'h00
      };
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata_o = state.rdata;
  assign sdout_o = state.sdout;
  assign sdout_oe_o = state.sdout_oe;
  assign gain_scheme_o = state.dsp_config[`SCHEME_SEL_BIT];
  assign enhancer_trigger_threshold_o = cfg.thresh_db;
  assign enhancer_gain_ceiling_o = cfg.enh_ceil_db;
  assign gain_ctrl_target_level_o = cfg.target_db;
  assign gain_ctrl_gain_ceiling_o = cfg.agc_ceil_db;
  assign gain_code_reserved_o = cfg.code_reserved;
  assign ch_enhancer_on_o = state.enh_on;
  assign ch_agc_on_o = state.agc_on;
  assign ch_powered_o = cfg.powered;
  assign device_mode_o = cfg.mode;
endmodule

// ### design/gain_ctrl_defs.svh
// register offsets, reset values, field positions and level constants
`ifndef GAIN_CTRL_DEFS_SVH
`define GAIN_CTRL_DEFS_SVH

`define ADDR_DSP_CONFIG 8'h6c
`define ADDR_RANGE_CFG 8'h6d
`define ADDR_GAIN_CFG 8'h70
`define ADDR_IN_EN 8'h73
`define ADDR_OUT_EN 8'h74
`define ADDR_POWER_CONFIGURATION 8'h75
`define ADDR_CH_STATUS 8'h76
`define ADDR_MODE_STATUS 8'h77

`define RST_DSP_CONFIG 8'h40
`define RST_RANGE_CFG 8'h7b
`define RST_GAIN_CFG 8'he7
`define RST_IN_EN 8'hf0
`define RST_OUT_EN 8'h00
`define RST_POWER_CONFIGURATION 8'h00

`define LEVEL_MSB 7
`define LEVEL_LSB 4
`define CEIL_MSB 3
`define CEIL_LSB 0
`define SCHEME_SEL_BIT 3
`define POWER_UP_BIT 6
`define PDM_ONLY_MASK 8'h0f

`define THRESH_MAX_CODE 4'h9
`define ENH_CEIL_MAX_CODE 4'hc
`define AGC_CEIL_MAX_CODE 4'hd

`define THRESH_BASE_DB 7'h0c
`define THRESH_STEP_DB 7'h06
`define ENH_CEIL_BASE_DB 7'h02
`define ENH_CEIL_STEP_DB 7'h02
`define TARGET_BASE_DB 7'h06
`define TARGET_STEP_DB 7'h02
`define AGC_CEIL_BASE_DB 7'h03
`define AGC_CEIL_STEP_DB 7'h03

`define MODE_SLEEP 3'h4
`define MODE_IDLE 3'h6
`define MODE_RUN 3'h7

`endif

// ### design/gain_ctrl_pkg.sv
// state types of the gain control register group
package gain_ctrl_pkg;

  typedef struct packed {
    logic [7:0] dsp_config;
    logic [7:0] range_cfg;
    logic [7:0] gain_cfg;
    logic [7:0] in_en;
    logic [7:0] out_en;
    logic [7:0] power_configuration;
    logic [7:0] rdata;
    logic sdout;
    logic sdout_oe;
    logic [7:0] enh_on;
    logic [7:0] agc_on;
  } bank_state_type;

  typedef struct packed {
    logic [6:0] thresh_db;
    logic [6:0] enh_ceil_db;
    logic [6:0] target_db;
    logic [6:0] agc_ceil_db;
    logic reserved;
  } level_state_type;

  typedef struct packed {
    logic [7:0] powered;
    logic [2:0] mode;
  } power_state_type;

endpackage

// ### design/gain_ctrl_if.sv
// configuration and results shared between the bank and its helpers
`timescale 1ns/100ps
interface gain_ctrl_if;
  logic [3:0] thresh_code;
  logic [3:0] enh_ceil_code;
  logic [3:0] target_code;
  logic [3:0] agc_ceil_code;
  logic [6:0] thresh_db;
  logic [6:0] enh_ceil_db;
  logic [6:0] target_db;
  logic [6:0] agc_ceil_db;
  logic code_reserved;
  logic [7:0] in_en;
  logic [7:0] pdm_source;
  logic power_up;
  logic sleep;
  logic [7:0] powered;
  logic [2:0] mode;

  modport bank (
    output thresh_code, enh_ceil_code, target_code, agc_ceil_code,
    output in_en, pdm_source, power_up, sleep,
    input thresh_db, enh_ceil_db, target_db, agc_ceil_db,
    input code_reserved, powered, mode
  );
  modport level (
    input thresh_code, enh_ceil_code, target_code, agc_ceil_code,
    output thresh_db, enh_ceil_db, target_db, agc_ceil_db, code_reserved
  );
  modport power (
    input in_en, pdm_source, power_up, sleep,
    output powered, mode
  );
endinterface

// ### design/gain_level_decoder.sv
// turns stored codes into level magnitudes in whole dB
`timescale 1ns/100ps
`include "gain_ctrl_defs.svh"
module gain_level_decoder
  import gain_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // codes in, levels out
  gain_ctrl_if.level lv
);
  level_state_type state;
  level_state_type next_state;
  logic [3:0] thr;
  logic [3:0] ecl;
  logic [3:0] acl;

  always_comb begin
    next_state = state;
    // reserved codes clamp to the top documented code
    thr = (lv.thresh_code > `THRESH_MAX_CODE) ?
      `THRESH_MAX_CODE : lv.thresh_code;
    ecl = (lv.enh_ceil_code > `ENH_CEIL_MAX_CODE) ?
      `ENH_CEIL_MAX_CODE : lv.enh_ceil_code;
    acl = (lv.agc_ceil_code > `AGC_CEIL_MAX_CODE) ?
      `AGC_CEIL_MAX_CODE : lv.agc_ceil_code;
    // uniform step from the lowest code
    next_state.thresh_db = `THRESH_BASE_DB +
      `THRESH_STEP_DB * {3'h0, thr};
    next_state.enh_ceil_db = `ENH_CEIL_BASE_DB +
      `ENH_CEIL_STEP_DB * {3'h0, ecl};
    next_state.target_db = `TARGET_BASE_DB +
      `TARGET_STEP_DB * {3'h0, lv.target_code};
    next_state.agc_ceil_db = `AGC_CEIL_BASE_DB +
      `AGC_CEIL_STEP_DB * {3'h0, acl};
    next_state.reserved = (thr != lv.thresh_code) ||
      (ecl != lv.enh_ceil_code) || (acl != lv.agc_ceil_code);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign lv.thresh_db = state.thresh_db;
  assign lv.enh_ceil_db = state.enh_ceil_db;
  assign lv.target_db = state.target_db;
  assign lv.agc_ceil_db = state.agc_ceil_db;
  assign lv.code_reserved = state.reserved;
endmodule

// ### design/channel_power_ctrl.sv
// per-channel power state and device mode
`timescale 1ns/100ps
`include "gain_ctrl_defs.svh"
module channel_power_ctrl
  import gain_ctrl_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // enables in, power state out
  gain_ctrl_if.power pw
);
  power_state_type state;
  power_state_type next_state;
  logic [7:0] want;
  // a literal cannot be bit-selected, so the mask gets a name
  localparam logic [7:0] pdm_only = `PDM_ONLY_MASK;

  // a pdm-only channel fed from anything else stays off
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      assign want[g] = pw.power_up && pw.in_en[g] && !pw.sleep &&
        (!pdm_only[g] || pw.pdm_source[g]);
    end
  endgenerate

  always_comb begin
    next_state = state;
    next_state.powered = want;
    if (pw.sleep) begin
      next_state.mode = `MODE_SLEEP;
    end else if (want == 8'h00) begin
      next_state.mode = `MODE_IDLE;
    end else begin
      next_state.mode = `MODE_RUN;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= '{powered: 8'h00, mode: `MODE_SLEEP};
    end else begin
      state <= next_state;
    end
  end

  assign pw.powered = state.powered;
  assign pw.mode = state.mode;
endmodule

// ### tb/gain_ctrl_regs_sva.sv
// assertions on the ports of the gain control register group
`timescale 1ns/100ps
module gain_ctrl_regs_sva (
  // clock, reset and register port
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  // channel and slot side
  input wire logic [7:0] pdm_source_i,
  input wire logic device_sleep_i,
  input wire logic slot_active_i,
  input wire logic sdout_o,
  input wire logic sdout_oe_o,
  input wire logic [6:0] enhancer_trigger_threshold_o,
  input wire logic [7:0] ch_enhancer_on_o,
  input wire logic [7:0] ch_agc_on_o,
  input wire logic [7:0] ch_powered_o,
  input wire logic [2:0] device_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // two edges of sleep so the mode has caught up
  sequence s_asleep;
    device_sleep_i ##1 device_sleep_i;
  endsequence
  a_rdata_idle: assert property (!reg_read_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
  a_unmapped_zero: assert property (reg_read_i && reg_addr_i == 8'h00
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_thresh_range: assert property (!$past(sys_rst_i)
    |-> enhancer_trigger_threshold_o inside {[7'h0c:7'h42]})
    else $error("threshold out of range");
  a_sleep_off: assert property (device_sleep_i |=> ch_powered_o == 8'h00)
    else $error("channel powered while asleep");
  a_pdm_only: assert property ((ch_powered_o & 8'h0f
    & ~$past(pdm_source_i)) == 8'h00) else $error("non pdm channel up");
  a_gain_follows: assert property (((ch_enhancer_on_o | ch_agc_on_o)
    & ~$past(ch_powered_o)) == 8'h00) else $error("gain on unpowered");
  a_one_scheme: assert property ((ch_enhancer_on_o & ch_agc_on_o) == 8'h00)
    else $error("both schemes on one channel");
  a_mode_sleep: assert property (s_asleep |-> device_mode_o == 3'h4)
    else $error("mode not sleep");
  a_slot_quiet: assert property (!sdout_oe_o |-> !sdout_o)
    else $error("data while tri-stated");
  a_slot_idle: assert property (!slot_active_i |=> !sdout_oe_o)
    else $error("slot driven when idle");
endmodule

bind gain_ctrl_channel_enable_regs gain_ctrl_regs_sva i_sva (
  .clk_i, .sys_rst_i, .reg_addr_i, .reg_read_i, .reg_rdata_o,
  .pdm_source_i, .device_sleep_i, .slot_active_i, .sdout_o, .sdout_oe_o,
  .enhancer_trigger_threshold_o, .ch_enhancer_on_o, .ch_agc_on_o,
  .ch_powered_o, .device_mode_o
);

// ### tb/tb_gain_ctrl_channel_enable_regs.sv
// self-checking bench for the gain control register group
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
  fail_count++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_gain_ctrl_channel_enable_regs;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_write_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic [7:0] pdm_source_i = 8'h00;
  logic [7:0] ch_gain_ctrl_en_i = 8'hff;
  logic device_sleep_i = 1'b0;
  logic [2:0] slot_index_i = 3'h0;
  logic slot_active_i = 1'b0;
  logic slot_bit_i = 1'b0;
  logic [7:0] reg_rdata_o, ch_enhancer_on_o, ch_agc_on_o, ch_powered_o;
  logic sdout_o, sdout_oe_o, gain_scheme_o, gain_code_reserved_o;
  logic [6:0] enhancer_trigger_threshold_o, enhancer_gain_ceiling_o;
  logic [6:0] gain_ctrl_target_level_o, gain_ctrl_gain_ceiling_o;
  logic [2:0] device_mode_o;
  int fail_count = 0;
  int n_compared = 0;

  gain_ctrl_channel_enable_regs i_gain_ctrl_channel_enable_regs (
    .clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
    .reg_read_i, .reg_rdata_o, .pdm_source_i, .ch_gain_ctrl_en_i,
    .device_sleep_i, .slot_index_i, .slot_active_i, .slot_bit_i,
    .sdout_o, .sdout_oe_o, .gain_scheme_o, .enhancer_trigger_threshold_o,
    .enhancer_gain_ceiling_o, .gain_ctrl_target_level_o,
    .gain_ctrl_gain_ceiling_o, .gain_code_reserved_o, .ch_enhancer_on_o,
    .ch_agc_on_o, .ch_powered_o, .device_mode_o
  );

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic end_of_test;
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // gap cycle after each write keeps strobes single-driven per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clk_i);
    reg_write_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clk_i);
    reg_read_i <= 1'b0;
    #1;
    `CHK(reg_rdata_o, e)
  endtask

  // levels and power trail the registers by up to two edges
  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic t_reset_regs;
    `CHK(enhancer_trigger_threshold_o, 7'h36)
    `CHK(enhancer_gain_ceiling_o, 7'h18)
    `CHK(gain_ctrl_target_level_o, 7'h22)
    `CHK(gain_ctrl_gain_ceiling_o, 7'h18)
    rd(8'h6d, 8'h7b);
    rd(8'h70, 8'he7);
    rd(8'h73, 8'hf0);
    rd(8'h74, 8'h00);
    rd(8'h6c, 8'h40);
    rd(8'h75, 8'h00);
    wr(8'h76, 8'hff);
    rd(8'h76, 8'h00);
    rd(8'h00, 8'h00);
  endtask

  task automatic t_levels;
    wr(8'h70, 8'h5a);
    wr(8'h6d, 8'h9c);
    rd(8'h70, 8'h5a);
    settle();
    `CHK(gain_ctrl_target_level_o, 7'h10)
    `CHK(gain_ctrl_gain_ceiling_o, 7'h21)
    `CHK(enhancer_trigger_threshold_o, 7'h42)
    `CHK(enhancer_gain_ceiling_o, 7'h1a)
    `CHK(gain_code_reserved_o, 1'b0)
    wr(8'h70, 8'hf0);
    wr(8'h6d, 8'h0d);
    settle();
    `CHK(gain_ctrl_target_level_o, 7'h24)
    `CHK(gain_ctrl_gain_ceiling_o, 7'h03)
    `CHK(enhancer_trigger_threshold_o, 7'h0c)
    `CHK(gain_code_reserved_o, 1'b1)
    rd(8'h6d, 8'h0d);
    wr(8'h6d, 8'ha0);
    wr(8'h70, 8'h0e);
    settle();
    `CHK(gain_code_reserved_o, 1'b1)
    rd(8'h70, 8'h0e);
    wr(8'h6d, 8'h7b);
    wr(8'h70, 8'he7);
    settle();
    `CHK(gain_code_reserved_o, 1'b0)
  endtask

  task automatic t_slots;
    wr(8'h74, 8'h81);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      slot_active_i <= 1'b1;
      slot_index_i <= 3'(i);
      slot_bit_i <= 1'(i >> 1);
      @(posedge clk_i);
      #1;
      `CHK(sdout_oe_o, 1'(i == 0 || i == 7))
      `CHK(sdout_o, 1'(i == 7))
    end
    @(posedge clk_i);
    slot_active_i <= 1'b0;
  endtask

  task automatic t_power;
    wr(8'h75, 8'h40);
    settle();
    `CHK(ch_powered_o, 8'hf0)
    `CHK(device_mode_o, 3'h7)
    `CHK(ch_enhancer_on_o, 8'hf0)
    rd(8'h77, 8'he0);
    wr(8'h73, 8'hff);
    pdm_source_i <= 8'h05;
    settle();
    `CHK(ch_powered_o, 8'hf5)
    rd(8'h76, 8'hf5);
    wr(8'h6c, 8'h48);
    ch_gain_ctrl_en_i <= 8'h81;
    settle();
    `CHK(gain_scheme_o, 1'b1)
    `CHK(ch_agc_on_o, 8'h81)
    `CHK(ch_enhancer_on_o, 8'h00)
    @(posedge clk_i);
    device_sleep_i <= 1'b1;
    settle();
    `CHK(ch_powered_o, 8'h00)
    `CHK(device_mode_o, 3'h4)
    @(posedge clk_i);
    device_sleep_i <= 1'b0;
    wr(8'h75, 8'h00);
    settle();
    `CHK(ch_powered_o, 8'h00)
    `CHK(device_mode_o, 3'h6)
  endtask

  initial begin
    repeat (2000) @(posedge clk_i);
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    settle();
    t_reset_regs();
    t_levels();
    t_slots();
    t_power();
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(8'h73, 8'hf0);
    end_of_test();
  end
endmodule
